// *** logic/msac_split_ctrl.sv ***
// Instruction/data split, chip select and wait-state control with APB regs
`timescale 1ns/100ps
// Summary of operation
// - Split inversions act only on root and data segment, the low 52K.
// - Split register bits 7:6 are ignored and always read zero.
// - Bit 5 clear: selected inversions apply to fetches and data alike.
// - Bit 5 set: inversions apply to data accesses only, never fetches.
// - Bit 4 set holds chip_select_one active; clear means normal decode.
// - Bit 3 set inverts A19 on data segment access before bank decode.
// - Bit 2 set inverts A16 on data segment access in the low 52K.
// - Bit 1 set inverts A19 on root access before bank decode.
// - Bit 0 set inverts A16 on root access in the low 52K.
// - bank_zero_control resets with write_strobe_zero inhibited.
// - After reset, fetch starts at address zero on chip_select_zero.
// - Opcode 0xff is restart: push program counter, vector to 0x70.
// - Internal I/O cycles keep external chip selects inactive, except chip_select_one while bit 4 is set.
// - Fetch after a not-taken branch gets full programmed wait states.
// - First fetch after multiply_instruction gets programmed waits.
// - Block moves: later reads use write-target waits, external I/O reads none.
module msac_split_ctrl
    import msac_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic [DATA_W-1:0]       prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               req_valid,
    input  wire msac_req_type       req,
    output logic                    req_ready,
    output logic                    req_done,
    output msac_pins_type           mem,
    input  wire logic               opcode_valid,
    input  wire logic [7:0]         opcode,
    output logic                    pc_load,
    output logic [ADDR_W-1:0]       pc_value,
    output logic                    pc_push
);

    // ========================================================
    // APB register file
    logic [7:0]        split_q;
    logic [7:0]        split_d;
    logic [7:0]        io_wait_q;
    logic [7:0]        io_wait_d;
    logic [7:0]        bank_q [NUM_BANK];
    logic [7:0]        bank_d [NUM_BANK];
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic              pready_q;
    logic              pready_d;
    logic              pslverr_q;
    logic              pslverr_d;
    logic              setup_ph;
    logic              wr_en;
    logic              hit_bank;
    logic              hit_any;
    logic [1:0]        bank_idx;
    logic [DATA_W-1:0] rd_mux;
    logic              busy_q;
    logic [1:0]        last_bank_q;

    assign setup_ph = psel & ~penable;
    assign wr_en    = psel & penable & pwrite & pready_q & ~pslverr_q;
    assign bank_idx = paddr[3:2];
    assign hit_bank = (paddr[7:4] == OFS_BANK_BASE[7:4])
                    & (paddr[1:0] == 2'h0);
    assign hit_any  = hit_bank | (paddr == OFS_SPLIT)
                    | (paddr == OFS_IO_WAIT) | (paddr == OFS_STATUS);

    always_comb begin
        rd_mux = '0;
        if (paddr == OFS_SPLIT) begin
            rd_mux[7:0] = split_q & SPL_WMASK;
        end else if (paddr == OFS_IO_WAIT) begin
            rd_mux[7:0] = io_wait_q;
        end else if (paddr == OFS_STATUS) begin
            rd_mux[0]   = busy_q;
            rd_mux[2:1] = last_bank_q;
        end else if (hit_bank) begin
            rd_mux[7:0] = bank_q[bank_idx];
        end
    end

    always_comb begin
        split_d   = split_q;
        io_wait_d = io_wait_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (setup_ph) begin
            prdata_d  = pwrite ? '0 : rd_mux;
            pready_d  = 1'b1;
            pslverr_d = ~hit_any | (pwrite & (paddr == OFS_STATUS));
        end else if (psel & penable & ~pready_q) begin
            pready_d  = 1'b1;
        end
        if (wr_en & (paddr == OFS_SPLIT)) begin
            // Top two bits are never stored
            split_d = pwdata[7:0] & SPL_WMASK;
        end
        if (wr_en & (paddr == OFS_IO_WAIT)) begin
            io_wait_d = {5'h00, pwdata[WAIT_W-1:0]};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            split_q   <= SPL_RST;
            io_wait_q <= IOW_RST;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            split_q   <= split_d;
            io_wait_q <= io_wait_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ========================================================
    // Bank select registers
    for (genvar i = 0; i < NUM_BANK; i++) begin : g_bank
        localparam logic [7:0] RST_VAL = (i == 0) ? BNK0_RST : BNKN_RST;
        always_comb begin
            bank_d[i] = bank_q[i];
            if (wr_en & hit_bank & (bank_idx == 2'(i))) begin
                bank_d[i] = pwdata[7:0] & BNK_WMASK;
            end
        end
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                // Bank zero boots write-inhibited
                bank_q[i] <= RST_VAL;
            end else if (ce) begin
                bank_q[i] <= bank_d[i];
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ========================================================
    // Address translation
    logic              in_low;
    logic              root_hit;
    logic              dseg_hit;
    logic              apply_inv;
    logic [ADDR_W-1:0] tr_addr;
    logic [1:0]        tr_bank;
    logic [1:0]        wr_bank;
    logic [7:0]        tr_cfg;
    logic [WAIT_W-1:0] waits;

    always_comb begin
        in_low    = req.logical < SPLIT_LIMIT;
        root_hit  = req.root & in_low;
        dseg_hit  = req.dseg & in_low;
        // Fetches bypass inversion only in split mode
        apply_inv = ~split_q[SPL_DATA_ONLY] | ~req.fetch;
        tr_addr   = req.phys;
        tr_addr[A16_BIT] = req.phys[A16_BIT]
            ^ (apply_inv & root_hit & split_q[SPL_INV16_ROOT])
            ^ (apply_inv & dseg_hit & split_q[SPL_INV16_DSEG]);
        tr_addr[A19_BIT] = req.phys[A19_BIT]
            ^ (apply_inv & root_hit & split_q[SPL_INV19_ROOT])
            ^ (apply_inv & dseg_hit & split_q[SPL_INV19_DSEG]);
        // Bank choice is made on the inverted address
        tr_bank = tr_addr[BANK_LSB+1:BANK_LSB];
        wr_bank = req.blk_wr_phys[BANK_LSB+1:BANK_LSB];
        tr_cfg  = bank_q[tr_bank];
    end

    // Wait-state choice per cycle kind
    always_comb begin
        waits = tr_cfg[BNK_WAIT_LSB +: WAIT_W];
        if (req.ext_io) begin
            waits = io_wait_q[WAIT_W-1:0];
            if (req.blk_later & ~req.write) begin
                waits = '0;
            end
        end else if (req.blk_later & ~req.write) begin
            // Later block-move reads take the destination's waits
            waits = bank_q[wr_bank][BNK_WAIT_LSB +: WAIT_W];
        end
    end

    // ========================================================
    // External cycle sequencer
    msac_state_type    state_q;
    msac_state_type    state_d;
    msac_pins_type     mem_q;
    msac_pins_type     mem_d;
    logic              ready_q;
    logic              ready_d;
    logic              done_q;
    logic              done_d;
    logic              busy_d;
    logic [1:0]        last_bank_d;
    logic              take;
    logic              expired;
    logic [NUM_CS-1:0] force_mask;

    assign take = req_valid & ready_q;
    assign force_mask = split_q[SPL_FORCE_CS1]
                      ? NUM_CS'(1 << CS_ONE) : '0;

    msac_wait_timer u_timer (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .load    (take),
        .count   (waits),
        .expired (expired)
    );

    always_comb begin
        state_d     = state_q;
        mem_d       = mem_q;
        ready_d     = ready_q;
        done_d      = 1'b0;
        busy_d      = busy_q;
        last_bank_d = last_bank_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d   = ST_ACCESS;
                    ready_d   = 1'b0;
                    busy_d    = 1'b1;
                    mem_d.addr = tr_addr;
                    mem_d.cs_n = '1;
                    mem_d.oe_n = 1'b1;
                    mem_d.we_n = 1'b1;
                    // Internal and external I/O leave memory selects idle
                    if (~req.int_io & ~req.ext_io) begin
                        mem_d.cs_n[tr_cfg[BNK_CS_LSB +: BNK_CS_W]] = 1'b0;
                        mem_d.oe_n = req.write;
                        mem_d.we_n = ~req.write | tr_cfg[BNK_WINH];
                        last_bank_d = tr_bank;
                    end
                end
            end
            ST_ACCESS: begin
                if (expired) begin
                    state_d    = ST_IDLE;
                    ready_d    = 1'b1;
                    done_d     = 1'b1;
                    busy_d     = 1'b0;
                    mem_d.cs_n = '1;
                    mem_d.oe_n = 1'b1;
                    mem_d.we_n = 1'b1;
                end
            end
        endcase
        // Forced select stays low in every state
        mem_d.cs_n = mem_d.cs_n & ~force_mask;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            // Boot address decodes to bank zero and chip_select_zero
            mem_q.addr  <= BOOT_ADDR;
            mem_q.cs_n  <= '1;
            mem_q.oe_n  <= 1'b1;
            mem_q.we_n  <= 1'b1;
            ready_q     <= 1'b1;
            done_q      <= 1'b0;
            busy_q      <= 1'b0;
            last_bank_q <= 2'h0;
        end else if (ce) begin
            state_q     <= state_d;
            mem_q       <= mem_d;
            ready_q     <= ready_d;
            done_q      <= done_d;
            busy_q      <= busy_d;
            last_bank_q <= last_bank_d;
        end
    end

    assign mem       = mem_q;
    assign req_ready = ready_q;
    assign req_done  = done_q;

    // ========================================================
    // Program counter load: boot and restart opcode
    logic              boot_q;
    logic              boot_d;
    logic              pc_load_q;
    logic              pc_load_d;
    logic              pc_push_q;
    logic              pc_push_d;
    logic [ADDR_W-1:0] pc_value_q;
    logic [ADDR_W-1:0] pc_value_d;

    always_comb begin
        boot_d     = 1'b0;
        pc_load_d  = 1'b0;
        pc_push_d  = 1'b0;
        pc_value_d = pc_value_q;
        if (boot_q) begin
            pc_load_d  = 1'b1;
            pc_value_d = BOOT_ADDR;
        end else if (opcode_valid & (opcode == RST_OPCODE)) begin
            // Restart pushes the old counter, then vectors
            pc_load_d  = 1'b1;
            pc_push_d  = 1'b1;
            pc_value_d = RST_VECTOR;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boot_q     <= 1'b1;
            pc_load_q  <= 1'b0;
            pc_push_q  <= 1'b0;
            pc_value_q <= BOOT_ADDR;
        end else if (ce) begin
            boot_q     <= boot_d;
            pc_load_q  <= pc_load_d;
            pc_push_q  <= pc_push_d;
            pc_value_q <= pc_value_d;
        end
    end

    assign pc_load  = pc_load_q;
    assign pc_push  = pc_push_q;
    assign pc_value = pc_value_q;

endmodule

// *** logic/msac_pkg.sv ***
// Constants, field layouts and carrier types for the memory split control
package msac_pkg;

    // ========================================================
    // Bus and address widths
    localparam int PADDR_W  = 8;
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 20;
    localparam int LOG_W    = 16;
    localparam int NUM_BANK = 4;
    localparam int NUM_CS   = 4;
    localparam int WAIT_W   = 3;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_SPLIT     = 8'h10;
    localparam logic [7:0] OFS_IO_WAIT   = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_BANK_BASE = 8'h20;

    // ========================================================
    // Split control fields
    localparam int SPL_INV16_ROOT = 0;
    localparam int SPL_INV19_ROOT = 1;
    localparam int SPL_INV16_DSEG = 2;
    localparam int SPL_INV19_DSEG = 3;
    localparam int SPL_FORCE_CS1  = 4;
    localparam int SPL_DATA_ONLY  = 5;
    localparam logic [7:0] SPL_WMASK = 8'h3f;
    localparam logic [7:0] SPL_RST   = 8'h00;

    // ========================================================
    // Bank select register fields
    localparam int BNK_WAIT_LSB = 0;
    localparam int BNK_WINH     = 3;
    localparam int BNK_CS_LSB   = 4;
    localparam int BNK_CS_W     = 2;
    localparam logic [7:0] BNK_WMASK  = 8'h3f;
    localparam logic [7:0] BNK0_RST   = 8'h0f;
    localparam logic [7:0] BNKN_RST   = 8'h00;
    localparam logic [7:0] IOW_RST    = 8'h00;

    // ========================================================
    // Address bits, regions and fixed vectors
    localparam int A16_BIT  = 16;
    localparam int A19_BIT  = 19;
    localparam int BANK_LSB = 18;
    localparam int CS_ONE   = 1;
    localparam logic [LOG_W-1:0]  SPLIT_LIMIT = 16'hd000;
    localparam logic [7:0]        RST_OPCODE  = 8'hff;
    localparam logic [ADDR_W-1:0] RST_VECTOR  = 20'h00070;
    localparam logic [ADDR_W-1:0] BOOT_ADDR   = 20'h00000;

    // ========================================================
    // Carrier types
    typedef struct packed {
        logic [ADDR_W-1:0] phys;
        logic [LOG_W-1:0]  logical;
        logic              fetch;
        logic              write;
        logic              int_io;
        logic              ext_io;
        logic              root;
        logic              dseg;
        logic              blk_later;
        logic [ADDR_W-1:0] blk_wr_phys;
    } msac_req_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [NUM_CS-1:0] cs_n;
        logic              oe_n;
        logic              we_n;
    } msac_pins_type;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ACCESS
    } msac_state_type;

endpackage

// *** logic/msac_wait_timer.sv ***
// Wait-state down counter for one external memory cycle
`timescale 1ns/100ps
module msac_wait_timer
    import msac_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              load,
    input  wire logic [WAIT_W-1:0] count,
    output logic                   expired
);

    // ========================================================
    // Counter
    logic [WAIT_W-1:0] cnt_q;
    logic [WAIT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - WAIT_W'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign expired = (cnt_q == '0);

endmodule

// *** sim/msac_mem_model.sv ***
// Behavioural model of the external flash and SRAM on the memory pins
`timescale 1ns/100ps
module msac_mem_model
    import msac_pkg::*;
(
    input  wire logic          mclk,
    input  wire msac_pins_type mem,
    output int                 wr_count
);
    // ==================
    // Write capture
    // A part only latches data on a falling strobe while selected
    logic we_q = 1'b1;
    int   n_wr = 0;
    always @(posedge mclk) begin
        if (we_q && !mem.we_n && mem.cs_n != 4'hf) begin
            n_wr <= n_wr + 1;
        end
        we_q <= mem.we_n;
    end
    assign wr_count = n_wr;
endmodule

// *** sim/msac_split_ctrl_chk.sv ***
// Port-level checker for the memory split control block
`timescale 1ns/100ps
module msac_split_ctrl_chk
    import msac_pkg::*;
(
    input wire logic               mclk,
    input wire logic               rst,
    input wire logic               ce,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [DATA_W-1:0]  pwdata,
    input wire logic [DATA_W-1:0]  prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               req_valid,
    input wire msac_req_type       req,
    input wire logic               req_ready,
    input wire logic               req_done,
    input wire msac_pins_type      mem,
    input wire logic               opcode_valid,
    input wire logic [7:0]         opcode,
    input wire logic               pc_load,
    input wire logic [ADDR_W-1:0]  pc_value,
    input wire logic               pc_push
);
    // ==================
    // Helper state
    // Reset bank settings hold only until software writes anything
    logic wr_seen_q;
    logic wr_seen_d;
    logic take;
    logic boot;
    assign take = req_valid && req_ready && ce;
    assign boot = !wr_seen_q && take && !req.int_io && !req.ext_io
        && req.phys[19:18] == 2'b00;
    always_comb begin
        wr_seen_d = wr_seen_q | (psel & penable & pready & pwrite);
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_seen_q <= 1'b0;
        end else begin
            wr_seen_q <= wr_seen_d;
        end
    end
    // ==================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_restart_vector: assert property (
        ce && opcode_valid && opcode == RST_OPCODE
        |=> pc_load && pc_push && pc_value == RST_VECTOR)
        else $error("restart vector not loaded");
    a_boot_fetch: assert property (
        ce && $fell(rst) |=> pc_load && pc_value == BOOT_ADDR)
        else $error("boot fetch not at zero");
    a_boot_cs_zero: assert property (
        boot && !req.write |=> !mem.cs_n[0] && !mem.oe_n)
        else $error("boot read not on chip select zero");
    a_write_inhibit: assert property (
        boot && req.write |=> mem.we_n [*8])
        else $error("write strobe zero not inhibited");
    a_io_quiet: assert property (
        take && req.int_io
        |=> mem.cs_n[0] && mem.cs_n[3:2] == 2'b11 && mem.oe_n && mem.we_n)
        else $error("chip select active in internal io");
    a_split_top_zero: assert property (
        pready && psel && !pwrite && paddr == OFS_SPLIT
        |-> prdata[31:6] == 26'h0)
        else $error("split register top bits not zero");
    a_done_bound: assert property (
        take |=> !req_ready ##[1:8] req_done)
        else $error("memory cycle length wrong");
    a_pready_pulse: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");
    c_fetch: cover property (take && req.fetch);
    c_blk_later: cover property (take && req.blk_later);
    c_restart: cover property (opcode_valid && opcode == RST_OPCODE);
endmodule

bind msac_split_ctrl msac_split_ctrl_chk u_chk (
    .mclk(mclk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .req_done(req_done), .mem(mem), .opcode_valid(opcode_valid),
    .opcode(opcode), .pc_load(pc_load), .pc_value(pc_value),
    .pc_push(pc_push)
);

// *** sim/memory_split_addr_control_bench.sv ***
// Self-checking bench for the memory split control block
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module memory_split_addr_control_bench
    import msac_pkg::*;
;
    logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, opcode, sp, iow;
    logic [31:0] pwdata, prdata, rd;
    logic        req_valid, req_ready, req_done, er;
    logic        opcode_valid, pc_load, pc_push;
    logic [19:0] pc_value;
    msac_req_type  req, r;
    msac_pins_type mem, pins;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          lat, wc, cyc = 0;
    logic [7:0]  bk [4];
    logic [7:0]  bv [4] = '{8'h00, 8'h13, 8'h25, 8'h37};
    logic [7:0]  sv [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0f, 8'h2f};
    logic [5:0]  kf [5] = '{6'h22, 6'h02, 6'h01, 6'h21, 6'h02};

    msac_split_ctrl u_dut (
        .mclk(mclk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .req_done(req_done), .mem(mem), .opcode_valid(opcode_valid),
        .opcode(opcode), .pc_load(pc_load), .pc_value(pc_value),
        .pc_push(pc_push)
    );
    msac_mem_model u_mem (.mclk(mclk), .mem(mem), .wr_count(wc));

    // ==================
    // Clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    // ==================
    // Tasks
    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic msac_req_type mk(input logic [19:0] p,
        input logic [15:0] l, input logic [5:0] f);
        mk = '0;
        mk.phys = p;
        mk.logical = l;
        {mk.fetch, mk.write, mk.int_io, mk.ext_io, mk.root, mk.dseg} = f;
    endfunction
    // Expected address after the split inversions
    function automatic logic [19:0] xl(input msac_req_type q);
        xl = q.phys;
        if (q.logical < SPLIT_LIMIT && !(sp[5] && q.fetch)) begin
            if (q.root) xl ^= {sp[1], 2'b0, sp[0], 16'h0};
            if (q.dseg) xl ^= {sp[3], 2'b0, sp[2], 16'h0};
        end
    endfunction
    task automatic acc(input msac_req_type q);
        logic [19:0] ea;
        logic        io;
        logic [3:0]  ecs;
        int          w;
        ea = xl(q);
        io = q.int_io | q.ext_io;
        ecs = io ? 4'h0 : (4'h1 << bk[ea[19:18]][5:4]);
        ecs[1] = ecs[1] | sp[4];
        w = bk[ea[19:18]][2:0];
        if (q.blk_later && !q.write) w = bk[q.blk_wr_phys[19:18]][2:0];
        if (q.ext_io) w = (q.blk_later && !q.write) ? 0 : iow;
        @(posedge mclk);
        req <= q;
        req_valid <= 1'b1;
        do @(posedge mclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        lat = 0;
        do begin
            @(negedge mclk);
            lat++;
            if (lat == 1) pins = mem;
        end while (req_done !== 1'b1 && lat < 20);
        if (!io) `CHK(pins.addr, ea)
        `CHK(pins.cs_n, ~ecs)
        `CHK({pins.oe_n, pins.we_n}, {q.write | io,
            !q.write | io | bk[ea[19:18]][3]})
        if (!q.int_io) `CHK(lat, 2 + w)
    endtask

    // ==================
    // Tests
    initial begin
        {rst, ce} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {req_valid, req, opcode_valid, opcode} = '0;
        {sp, iow} = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, OFS_SPLIT, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, OFS_BANK_BASE, 32'h0);
        `CHK(rd, 32'h0f)
        bk = '{8'h0f, 8'h00, 8'h00, 8'h00};
        acc(mk(20'h00000, 16'h0000, 6'h20));
        acc(mk(20'h00040, 16'h0040, 6'h10));
        `CHK(wc, 0)
        apb(1'b1, 8'h40, 32'h1);
        `CHK(er, 1'b1)
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_BANK_BASE + 8'(4 * i), {24'h0, bv[i] | 8'hc0});
            apb(1'b0, OFS_BANK_BASE + 8'(4 * i), 32'h0);
            `CHK(rd, {24'h0, bv[i]})
            bk[i] = bv[i];
        end
        acc(mk(20'h00040, 16'h0040, 6'h10));
        `CHK(wc, 1)
        apb(1'b1, OFS_SPLIT, 32'hff);
        apb(1'b0, OFS_SPLIT, 32'h0);
        `CHK(rd, 32'h3f)
        for (int i = 0; i < 6; i++) begin
            sp = sv[i];
            apb(1'b1, OFS_SPLIT, {24'h0, sp});
            for (int k = 0; k < 5; k++) begin
                acc(mk(20'h45123, k == 4 ? 16'hd123 : 16'h5123, kf[k]));
            end
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd, 32'h2)
        apb(1'b1, OFS_STATUS, 32'h1);
        `CHK(er, 1'b1)
        sp = 8'h10;
        apb(1'b1, OFS_SPLIT, 32'h10);
        acc(mk(20'h00200, 16'h0200, 6'h00));
        acc(mk(20'h00200, 16'h0200, 6'h08));
        sp = 8'h00;
        apb(1'b1, OFS_SPLIT, 32'h0);
        acc(mk(20'h00200, 16'h0200, 6'h08));
        iow = 8'h05;
        apb(1'b1, OFS_IO_WAIT, 32'h5);
        apb(1'b0, OFS_IO_WAIT, 32'h0);
        `CHK(rd, 32'h5)
        r = mk(20'hc0010, 16'h0010, 6'h00);
        acc(r);
        r.blk_later = 1'b1;
        r.blk_wr_phys = 20'h01000;
        acc(r);
        r = mk(20'h00020, 16'h0020, 6'h04);
        acc(r);
        r.blk_later = 1'b1;
        acc(r);
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            opcode_valid <= 1'b1;
            opcode <= i ? 8'h00 : RST_OPCODE;
            @(posedge mclk);
            opcode_valid <= 1'b0;
            @(negedge mclk);
            `CHK(pc_load, !i)
            if (i == 0)
                `CHK({pc_push, pc_value}, {1'b1, RST_VECTOR})
        end
        close_out();
    end
endmodule
